/* hdl/aps_link.sv */
`timescale 1ns/1ps
// link side: runs on the bit clock, shifts one frame per word clock period
module aps_link (
  input wire logic bclk_i,
  input wire logic rst_i,
  input wire logic wclk_i,
  input wire logic data_in_i,
  input wire aps_pkg::aps_cfg_t cfg_i,
  input wire aps_pkg::aps_pair_t tx_i,
  output logic data_out_o,
  output logic data_oe_n_o,
  output aps_pkg::aps_pair_t rx_o,
  output logic frame_tgl_o
);
  import aps_pkg::*;
  logic wclk_d_ff, nxt_wclk_d;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [5:0] bit_ff, nxt_bit;
  logic chan_ff, nxt_chan;
  logic run_ff, nxt_run;
  logic dout_ff, nxt_dout;
  logic oen_ff, nxt_oen;
  logic tgl_ff, nxt_tgl;
  aps_pair_t rx_ff, nxt_rx, sh_ff, nxt_sh;
  logic [5:0] len;
  logic slot_on;
  always_comb begin
    unique case (cfg_i.width_sel)
      2'h0: len = 6'h10;
      2'h1: len = 6'h14;
      2'h2: len = 6'h18;
      default: len = 6'h20;
    endcase
  end
  always_comb begin
    nxt_wclk_d = wclk_i;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_chan = chan_ff;
    nxt_run = run_ff;
    nxt_sh = sh_ff;
    nxt_rx = rx_ff;
    nxt_tgl = tgl_ff;
    nxt_dout = 1'b0;
    nxt_oen = 1'b1;
    slot_on = 1'b0;
    if (wclk_i && !wclk_d_ff) begin
      // frame start: delay placement by the programmed offset
      nxt_cnt = cfg_i.offset;
      nxt_bit = 6'h00;
      nxt_chan = 1'b0;
      nxt_run = cfg_i.port_en;
      nxt_sh = tx_i;
    end else if (run_ff) begin
      if (cnt_ff != 11'h000) begin
        nxt_cnt = cnt_ff - 11'h001;
      end else begin
        slot_on = chan_ff ? cfg_i.ch_en[1] : cfg_i.ch_en[0];
        if (bit_ff < len) begin
          if (chan_ff) begin
            nxt_dout = sh_ff.right[31];
            nxt_sh.right = {sh_ff.right[30:0], 1'b0};
            // msb-justified, so the top byte reads the same at every width
            nxt_rx.right[5'h1F - bit_ff[4:0]] = data_in_i;
          end else begin
            nxt_dout = sh_ff.left[31];
            nxt_sh.left = {sh_ff.left[30:0], 1'b0};
            nxt_rx.left[5'h1F - bit_ff[4:0]] = data_in_i;
          end
          // drive only own data bits: every one in normal mode, enabled slots only in tdm mode
          nxt_oen = !(cfg_i.drive_en && (!cfg_i.slot_mode || slot_on));
        end
        // tdm slots pack back to back, normal mode uses half frames
        if ((cfg_i.slot_mode && bit_ff == len - 6'h01) ||
            (!cfg_i.slot_mode && bit_ff == HALF_FRAME_BITS - 6'h01)) begin
          nxt_bit = 6'h00;
          nxt_chan = !chan_ff;
          if (chan_ff) begin
            nxt_run = 1'b0;
            nxt_tgl = !tgl_ff;
          end
        end else begin
          nxt_bit = bit_ff + 6'h01;
        end
      end
    end
  end
  always_ff @(posedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      wclk_d_ff <= 1'b0;
      cnt_ff <= 11'h000;
      bit_ff <= 6'h00;
      chan_ff <= 1'b0;
      run_ff <= 1'b0;
      sh_ff <= '0;
      rx_ff <= '0;
      tgl_ff <= 1'b0;
    end else begin
      wclk_d_ff <= nxt_wclk_d;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      chan_ff <= nxt_chan;
      run_ff <= nxt_run;
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      tgl_ff <= nxt_tgl;
    end
  end
  // output stage on the falling edge so the host samples on the rising edge
  always_ff @(negedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_ff <= 1'b0;
      oen_ff <= 1'b1;
    end else begin
      dout_ff <= nxt_dout;
      oen_ff <= nxt_oen;
    end
  end
  assign data_out_o = dout_ff;
  assign data_oe_n_o = oen_ff;
  assign rx_o = rx_ff;
  assign frame_tgl_o = tgl_ff;
endmodule

/* hdl/aps_pkg.sv */
package aps_pkg;
  localparam logic [7:0] REG_SLOT_MODE_CONTROL = 8'h2D;
  localparam logic [7:0] REG_PORT_CONTROL = 8'h2C;
  localparam logic [7:0] REG_CLOCK_CONTROL = 8'h2B;
  localparam logic [7:0] REG_DATA_OFFSET_LOW = 8'h30;
  localparam logic [7:0] REG_DATA_OFFSET_HIGH = 8'h31;
  localparam logic [7:0] REG_TX_LEFT = 8'h40;
  localparam logic [7:0] REG_TX_RIGHT = 8'h41;
  localparam logic [7:0] REG_STATUS = 8'h42;
  localparam int SLOT_MODE_BIT = 7;
  localparam int DRIVE_EN_BIT = 6;
  localparam int PORT_EN_BIT = 7;
  localparam int CLK_MASTER_BIT = 7;
  localparam logic SLOT_MODE_RST = 1'b0;
  localparam logic DRIVE_EN_RST = 1'b1;
  localparam logic [1:0] CH_EN_RST = 2'h0;
  localparam logic [1:0] WIDTH_RST = 2'h2;
  localparam logic PORT_EN_RST = 1'b0;
  localparam logic CLK_MASTER_RST = 1'b0;
  localparam logic [7:0] OFFSET_LOW_RST = 8'h00;
  localparam logic [2:0] OFFSET_HIGH_RST = 3'h0;
  localparam int OFFSET_W = 11;
  localparam logic [10:0] OFFSET_MAX = 11'h2FF;
  localparam logic [5:0] HALF_FRAME_BITS = 6'h20;
  localparam int CORE_CLK_HZ = 10000000;
  typedef struct packed {
    logic slot_mode;
    logic drive_en;
    logic [1:0] ch_en;
    logic port_en;
    logic [1:0] width_sel;
    logic [10:0] offset;
  } aps_cfg_t;
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } aps_pair_t;
endpackage

/* hdl/aps_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - tdm mode releases data line when idle
// - slot mode bit selects normal or tdm
// - drive enable gates serial data output
// - channel enables: bit0 left, bit1 right
// - data shifted n bit clocks after frame
// - zero offset keeps normal placement
// - offset is eleven bits, low plus high
// - port enable gates all data transfer
// - clock master select sets clock direction
// - width code selects 16/20/24/32 bits
module aps_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic bclk_i,
  input wire logic wclk_i,
  input wire logic data_in_i,
  output logic data_out_o,
  output logic data_oe_n_o,
  output logic clk_master_o
);
  import aps_pkg::*;
  logic slot_mode_ff, nxt_slot_mode;
  logic drive_en_ff, nxt_drive_en;
  logic [1:0] ch_en_ff, nxt_ch_en;
  logic port_en_ff, nxt_port_en;
  logic [1:0] width_ff, nxt_width;
  logic master_ff, nxt_master;
  logic [7:0] off_lo_ff, nxt_off_lo;
  logic [2:0] off_hi_ff, nxt_off_hi;
  logic [7:0] rdata_ff, nxt_rdata;
  aps_pair_t tx_ff, nxt_tx;
  aps_pair_t rx_hold_ff, nxt_rx_hold;
  logic [2:0] tgl_sync_ff, nxt_tgl_sync;
  logic [7:0] frames_ff, nxt_frames;
  aps_cfg_t cfg;
  aps_pair_t rx_link;
  logic tgl_link;
  always_comb begin
    cfg.slot_mode = slot_mode_ff;
    cfg.drive_en = drive_en_ff;
    cfg.ch_en = ch_en_ff;
    cfg.port_en = port_en_ff;
    cfg.width_sel = width_ff;
    cfg.offset = {off_hi_ff, off_lo_ff};
  end
  // config and tx words are quasi-static: software changes them between frames;
  // the link samples tx at frame start, which also brackets the crossing
  aps_link u_link (
    .bclk_i(bclk_i),
    .rst_i(rst_i),
    .wclk_i(wclk_i),
    .data_in_i(data_in_i),
    .cfg_i(cfg),
    .tx_i(tx_ff),
    .data_out_o(data_out_o),
    .data_oe_n_o(data_oe_n_o),
    .rx_o(rx_link),
    .frame_tgl_o(tgl_link)
  );
  always_comb begin
    nxt_slot_mode = slot_mode_ff;
    nxt_drive_en = drive_en_ff;
    nxt_ch_en = ch_en_ff;
    nxt_port_en = port_en_ff;
    nxt_width = width_ff;
    nxt_master = master_ff;
    nxt_off_lo = off_lo_ff;
    nxt_off_hi = off_hi_ff;
    nxt_tx = tx_ff;
    nxt_rx_hold = rx_hold_ff;
    nxt_tgl_sync = {tgl_sync_ff[1:0], tgl_link};
    nxt_frames = frames_ff;
    nxt_rdata = 8'h00;
    // frame-done event via toggle; rx word is stable after it until the next frame's first data bit
    if (tgl_sync_ff[2] != tgl_sync_ff[1]) begin
      nxt_rx_hold = rx_link;
      nxt_frames = frames_ff + 8'h01;
    end
    if (wr_i) begin
      unique case (addr_i)
        REG_SLOT_MODE_CONTROL: begin
          nxt_slot_mode = wdata_i[SLOT_MODE_BIT];
          nxt_drive_en = wdata_i[DRIVE_EN_BIT];
          nxt_ch_en = wdata_i[1:0];
        end
        REG_PORT_CONTROL: begin
          nxt_port_en = wdata_i[PORT_EN_BIT];
          nxt_width = wdata_i[3:2];
        end
        REG_CLOCK_CONTROL: nxt_master = wdata_i[CLK_MASTER_BIT];
        REG_DATA_OFFSET_LOW: nxt_off_lo = wdata_i;
        REG_DATA_OFFSET_HIGH: nxt_off_hi = wdata_i[2:0];
        REG_TX_LEFT: nxt_tx.left = {wdata_i, 24'h000000};
        REG_TX_RIGHT: nxt_tx.right = {wdata_i, 24'h000000};
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        REG_SLOT_MODE_CONTROL: nxt_rdata = {slot_mode_ff, drive_en_ff, 4'h0, ch_en_ff};
        REG_PORT_CONTROL: nxt_rdata = {port_en_ff, 3'h0, width_ff, 2'h0};
        REG_CLOCK_CONTROL: nxt_rdata = {master_ff, 7'h00};
        REG_DATA_OFFSET_LOW: nxt_rdata = off_lo_ff;
        REG_DATA_OFFSET_HIGH: nxt_rdata = {5'h00, off_hi_ff};
        REG_TX_LEFT: nxt_rdata = rx_hold_ff.left[31:24];
        REG_TX_RIGHT: nxt_rdata = rx_hold_ff.right[31:24];
        REG_STATUS: nxt_rdata = frames_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_mode_ff <= SLOT_MODE_RST;
      drive_en_ff <= DRIVE_EN_RST;
      ch_en_ff <= CH_EN_RST;
      port_en_ff <= PORT_EN_RST;
      width_ff <= WIDTH_RST;
      master_ff <= CLK_MASTER_RST;
      off_lo_ff <= OFFSET_LOW_RST;
      off_hi_ff <= OFFSET_HIGH_RST;
      rdata_ff <= 8'h00;
      tx_ff <= '0;
      rx_hold_ff <= '0;
      tgl_sync_ff <= 3'h0;
      frames_ff <= 8'h00;
    end else begin
      slot_mode_ff <= nxt_slot_mode;
      drive_en_ff <= nxt_drive_en;
      ch_en_ff <= nxt_ch_en;
      port_en_ff <= nxt_port_en;
      width_ff <= nxt_width;
      master_ff <= nxt_master;
      off_lo_ff <= nxt_off_lo;
      off_hi_ff <= nxt_off_hi;
      rdata_ff <= nxt_rdata;
      tx_ff <= nxt_tx;
      rx_hold_ff <= nxt_rx_hold;
      tgl_sync_ff <= nxt_tgl_sync;
      frames_ff <= nxt_frames;
    end
  end
  assign rdata_o = rdata_ff;
  // clocks are generated elsewhere; this only reports the chosen direction
  assign clk_master_o = master_ff;
endmodule

/* test/aps_host_model.sv */
`timescale 1ns/1ps
// host side: drives both link clocks, and the bit clock runs only inside a frame
module aps_host_model (
  output logic bclk_o,
  output logic wclk_o,
  output logic data_o,
  input wire logic data_i,
  input wire logic oe_n_i
);
  logic [0:1023] cap;
  logic [0:1023] oen;
  logic [7:0] rxb;
  initial begin
    bclk_o = 1'b0;
    wclk_o = 1'b0;
    data_o = 1'b0;
    rxb = 8'h00;
  end
  task automatic run_frame(input int n, input int len);
    int k;
    for (int c = 0; c < len; c++) begin
      #32 bclk_o = 1'b1;
      // a released line reads back inverted, so a stale level never passes
      cap[c] = oe_n_i ? !data_i : data_i;
      oen[c] = oe_n_i;
      #32 bclk_o = 1'b0;
      wclk_o = (c >= 7 && c < 39);
      k = c - 8 - n;
      // outside the sent byte the line toggles, so a stale bit never looks valid
      data_o = (k >= 0 && k < 8) ? rxb[7 - k] : ~data_o;
    end
  endtask
endmodule

/* test/aps_top_bench.sv */
`timescale 1ns/1ps
module aps_top_bench;
  logic core_clk_i, rst_i, wr_i, rd_i, bclk_i, wclk_i, data_in_i;
  logic data_out_o, data_oe_n_o, clk_master_o;
  logic [7:0] addr_i, wdata_i, rdata_o, last_rx;
  int fails;
  int samples_checked;
  int frames_sent;
  aps_top DUT (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .bclk_i,
    .wclk_i, .data_in_i, .data_out_o, .data_oe_n_o, .clk_master_o);
  aps_host_model HOST (.bclk_o(bclk_i), .wclk_o(wclk_i), .data_o(data_in_i),
    .data_i(data_out_o), .oe_n_i(data_oe_n_o));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk($sformatf("register %h", a), rdata_o, exp);
  endtask
  task automatic t_frame(input logic [7:0] mode, input logic [7:0] ctl, input int n);
    logic [7:0] b;
    logic drv;
    int w;
    int base;
    w = (ctl[3:2] == 2'h3) ? 32 : 16 + 4 * ctl[3:2];
    wr(8'h2D, mode);
    wr(8'h2C, ctl);
    wr(8'h30, n[7:0]);
    wr(8'h31, {5'h00, n[10:8]});
    wr(8'h40, mode ^ 8'h5A);
    wr(8'h41, ctl ^ 8'h96);
    HOST.rxb = mode ^ ctl ^ n[7:0];
    HOST.run_frame(n, n + 80);
    chk("lead-in oe_n", {7'h00, HOST.oen[8 + n]}, 8'h01);
    for (int s = 0; s < 2; s++) begin
      b = s ? ctl ^ 8'h96 : mode ^ 8'h5A;
      drv = ctl[7] && mode[6] && (!mode[7] || mode[s]);
      base = 9 + n + (s == 0 ? 0 : (mode[7] ? w : 32));
      for (int i = 0; i < w; i++) begin
        chk("oe_n", {7'h00, HOST.oen[base + i]}, {7'h00, !drv});
        if (drv) chk("data", {7'h00, HOST.cap[base + i]}, {7'h00, i < 8 && b[7 - i]});
      end
      if (s || !mode[7] && w < 32) chk("slot end", {7'h00, HOST.oen[base + w]}, 8'h01);
    end
    if (ctl[7]) begin
      last_rx = HOST.rxb;
      frames_sent++;
    end
    repeat (4) @(posedge core_clk_i);
    rc(8'h40, last_rx);
    rc(8'h42, frames_sent[7:0]);
  endtask
  task automatic t_regs;
    rc(8'h2D, 8'h40);
    rc(8'h30, 8'h00);
    rc(8'h31, 8'h00);
    rc(8'h2C, 8'h08);
    rc(8'h2B, 8'h00);
    rc(8'h55, 8'h00);
    wr(8'h2D, 8'hFF);
    rc(8'h2D, 8'hC3);
    wr(8'h31, 8'hFF);
    rc(8'h31, 8'h07);
  endtask
  task automatic t_master;
    wr(8'h2B, 8'h80);
    repeat (2) @(negedge core_clk_i);
    chk("clock master", {7'h00, clk_master_o}, 8'h01);
    wr(8'h2B, 8'h00);
    repeat (2) @(negedge core_clk_i);
    chk("clock master", {7'h00, clk_master_o}, 8'h00);
  endtask
  task automatic t_normal;
    t_frame(8'h40, 8'h80, 0);
    t_frame(8'h40, 8'h84, 3);
    t_frame(8'h40, 8'h88, 3);
    t_frame(8'h40, 8'h8C, 3);
  endtask
  task automatic t_tdm;
    t_frame(8'hC1, 8'h80, 5);
    t_frame(8'hC2, 8'h8C, 767);
    t_frame(8'hC3, 8'h84, 1);
    t_frame(8'hC0, 8'h80, 2);
  endtask
  task automatic t_gates;
    t_frame(8'h00, 8'h80, 0);
    t_frame(8'h40, 8'h00, 0);
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst_i, wr_i, rd_i} = 3'b100;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    last_rx = 8'h00;
    fails = 0;
    samples_checked = 0;
    frames_sent = 0;
    // reset must also see bit clock edges, with the word clock held low
    fork
      HOST.run_frame(0, 6);
    join_none
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_master();
    t_normal();
    t_tdm();
    t_gates();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fails++;
    final_report();
  end
endmodule

/* test/aps_top_sva.sv */
`timescale 1ns/1ps
module aps_top_sva (
  input wire logic core_clk_i, rst_i, wr_i, rd_i, bclk_i, wclk_i, data_in_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  input wire logic data_out_o, data_oe_n_o, clk_master_o
);
  logic [7:0] m_ff;
  logic [7:0] lo_ff;
  logic [2:0] hi_ff;
  logic port_ff;
  logic mst_ff;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_ff <= 8'h40;
      lo_ff <= 8'h00;
      hi_ff <= 3'h0;
      port_ff <= 1'b0;
      mst_ff <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        8'h2D: m_ff <= wdata_i & 8'hC3;
        8'h2C: port_ff <= wdata_i[7];
        8'h2B: mst_ff <= wdata_i[7];
        8'h30: lo_ff <= wdata_i;
        8'h31: hi_ff <= wdata_i[2:0];
        default: ;
      endcase
    end
  end
  // config only changes while the bit clock stands still, so no crossing lag here
  sequence s_frame_start;
    $rose(wclk_i);
  endsequence
  a_mode_readback: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_i && addr_i == 8'h2D |=> rdata_o == $past(m_ff)) else $error("mode readback wrong");
  a_offset_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_i && addr_i == 8'h30 |=> rdata_o == $past(lo_ff)) else $error("offset readback wrong");
  a_master_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_i && addr_i == 8'h2B |-> ##[1:2] clk_master_o == mst_ff) else $error("master level wrong");
  a_drive_gate: assert property (@(posedge bclk_i) disable iff (rst_i)
    !m_ff[6] |-> data_oe_n_o) else $error("driven while drive off");
  a_port_gate: assert property (@(posedge bclk_i) disable iff (rst_i)
    !port_ff |-> data_oe_n_o) else $error("driven while port off");
  a_tdm_quiet: assert property (@(posedge bclk_i) disable iff (rst_i)
    m_ff[7] && m_ff[1:0] == 2'h0 |-> data_oe_n_o) else $error("driven with no slot");
  a_frame_start: assert property (@(posedge bclk_i) disable iff (rst_i)
    s_frame_start |-> data_oe_n_o) else $error("driven before frame");
  a_zero_offset: assert property (@(posedge bclk_i) disable iff (rst_i)
    s_frame_start ##0 (lo_ff == 8'h00 && hi_ff == 3'h0 && port_ff && m_ff[6]
    && (!m_ff[7] || m_ff[0])) |=> !data_oe_n_o) else $error("zero offset start late");
endmodule
bind aps_top aps_top_sva CHK (.core_clk_i, .rst_i, .wr_i, .rd_i, .bclk_i, .wclk_i,
  .data_in_i, .addr_i, .wdata_i, .rdata_o, .data_out_o, .data_oe_n_o, .clk_master_o);
